// [inc/tweep_pkg.sv]
`default_nettype none
package tweep_pkg;
  // Device type nibble carried in the top of the address word
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int NINTH_CLK = 8;
  // Clock and internal program time
  localparam int CLK_PERIOD_NS = 4;
  localparam int INTERNAL_PROGRAM_TIME_MS = 5;
  // Longest time, so round down
  localparam int INTERNAL_PROGRAM_CYC = INTERNAL_PROGRAM_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
  // Controller quarter bit: 4 x 10 x 4 ns = 160 ns SCL period
  localparam int SCL_QTR_CYC = 10;
  localparam int SCL_QTR_MIN = 8;

  typedef enum logic [1:0] {
    TWEEP_1K = 2'h0,
    TWEEP_2K = 2'h1,
    TWEEP_4K = 2'h2,
    TWEEP_8K = 2'h3
  } tweep_variant_t;

  typedef enum logic [2:0] {
    CMD_START = 3'h0,
    CMD_STOP = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ = 3'h3,
    CMD_RECOVER = 3'h4
  } tweep_cmd_t;

  // Word address width per variant
  function automatic int tweep_addr_w(tweep_variant_t v);
    return 7 + int'(v);
  endfunction

  // Page offset bits per variant
  function automatic int tweep_page_w(tweep_variant_t v);
    return (v == TWEEP_4K || v == TWEEP_8K) ? 4 : 3;
  endfunction
endpackage
`default_nettype wire

// [inc/tweep_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tweep_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  wire logic sda;

  // Open-drain wired AND with pull-up
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (tgt_sda_oe && !tgt_sda_o));

  modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
  modport tgt (input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
endinterface
`default_nettype wire

// [design/tweep_target.sv]
`timescale 1ns/1ps
`default_nettype none
module tweep_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } tweep_fifo_s_t;
  tweep_fifo_s_t r, n;
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("tweep_fifo depth must be a power of two");
  end

  // Extra pointer bit tells full from empty
  assign in_ready = (r.wp ^ r.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = r.wp != r.rp;
  assign out_data = mem[r.rp[AW-1:0]];

  always_comb begin
    n = r;
    if (in_valid && in_ready) n.wp = r.wp + 1'b1;
    if (out_valid && out_ready) n.rp = r.rp + 1'b1;
  end

  always_ff @(posedge clock) begin
    if (in_valid && in_ready) mem[r.wp[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) r <= '0;
    else r <= n;
  end
endmodule // tweep_fifo

module tweep_target
  import tweep_pkg::*;
#(
  parameter tweep_variant_t VARIANT = TWEEP_2K,
  parameter int PROG_CYC = INTERNAL_PROGRAM_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst,
  tweep_if.tgt bus,
  input wire logic strap_select_hi,
  input wire logic strap_select_mid,
  input wire logic strap_select_lo,
  input wire logic prog_ready,
  output logic standby,
  output logic write_busy,
  output logic [9:0] cur_addr
);
  localparam int AW = tweep_addr_w(VARIANT);
  localparam int PW = tweep_page_w(VARIANT);
  localparam int TW = $clog2(PROG_CYC + 1);
  localparam logic [9:0] AMASK = 10'((1 << AW) - 1);
  localparam logic [9:0] PMASK = 10'((1 << PW) - 1);
  // Strap bits that really take part in the compare
  localparam logic [2:0] SEL_MASK = (VARIANT == TWEEP_8K) ? 3'h4 :
                                    (VARIANT == TWEEP_4K) ? 3'h6 : 3'h7;

  if (PROG_CYC < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("tweep_target parameters out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_WADR = 3'h3,
    ST_WDAT = 3'h2,
    ST_RDAT = 3'h6,
    ST_HOLD = 3'h7
  } tweep_tst_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [8:0] strap_s;
    logic scl_st;
    logic sda_st;
    logic [2:0] strap;
    tweep_tst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [9:0] addr;
    logic [1:0] hi;
    logic drv;
    logic pend;
    logic busy;
    logic [TW-1:0] tmr;
  } tweep_tgt_s_t;

  tweep_tgt_s_t r, n;
  logic [7:0] mem [1 << AW];
  logic [7:0] rd_byte;
  logic rise, fall, start_ev, stop_ev, dev_hit, push;
  logic f_in_ready, f_out_valid;
  logic [17:0] f_out;

  assign rd_byte = mem[r.addr[AW-1:0]];

  // Queue between the bus and the array; a full queue costs an ack
  tweep_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data({r.addr, r.sh}),
    .out_valid(f_out_valid),
    .out_ready(prog_ready),
    .out_data(f_out)
  );

  // Array takes bytes as the programmer paces them
  always_ff @(posedge clock) begin
    if (f_out_valid && prog_ready) mem[f_out[AW+7:8]] <= f_out[7:0];
  end

  // Low bits step, upper bits keep the page
  function automatic logic [9:0] page_step(logic [9:0] a);
    return (a & ~PMASK) | ((a + 10'h001) & PMASK);
  endfunction

  always_comb begin
    n = r;
    push = 1'b0;
    // Three-stage filter; first stage only feeds the second
    n.scl_s = {r.scl_s[1:0], bus.scl};
    n.sda_s = {r.sda_s[1:0], bus.sda};
    n.strap_s = {r.strap_s[5:0], strap_select_hi, strap_select_mid, strap_select_lo};
    if (r.scl_s[1] == r.scl_s[2]) n.scl_st = r.scl_s[2];
    if (r.sda_s[1] == r.sda_s[2]) n.sda_st = r.sda_s[2];
    if (r.strap_s[5:3] == r.strap_s[8:6]) n.strap = r.strap_s[8:6];
    rise = !r.scl_st && n.scl_st;
    fall = r.scl_st && !n.scl_st;
    // SDA moving under a high SCL is framing, never data
    start_ev = r.scl_st && n.scl_st && r.sda_st && !n.sda_st;
    stop_ev = r.scl_st && n.scl_st && !r.sda_st && n.sda_st;
    dev_hit = (r.sh[7:4] == DEV_TYPE_CODE)
              && (((r.sh[3:1] ^ r.strap) & SEL_MASK) == 3'h0)
              && !r.busy;
    // Program timer; queue must also be drained
    if (r.busy) begin
      if (r.tmr != '0) n.tmr = r.tmr - 1'b1;
      else if (!f_out_valid) n.busy = 1'b0;
    end
    if (start_ev) begin
      n.st = ST_DEV;
      n.cnt = 4'h0;
      n.drv = 1'b0;
    end else if (stop_ev) begin
      n.st = ST_IDLE;
      n.drv = 1'b0;
      if (r.pend) begin
        n.busy = 1'b1;
        n.tmr = TW'(PROG_CYC - 1);
        n.pend = 1'b0;
      end
    end else if (rise && r.st != ST_IDLE && r.st != ST_HOLD) begin
      if (r.cnt != 4'(NINTH_CLK)) begin
        n.sh = {r.sh[6:0], n.sda_st};
        n.cnt = r.cnt + 4'h1;
      end else begin
        n.cnt = 4'h9;
        // Own ack of the read address still drives; only data bytes step
        if (r.st == ST_RDAT && !r.drv) begin
          n.addr = (r.addr + 10'h001) & AMASK;
          if (n.sda_st) n.st = ST_HOLD;
        end
      end
    end else if (fall && r.st != ST_IDLE && r.st != ST_HOLD) begin
      if (r.cnt == 4'(NINTH_CLK)) begin
        n.drv = 1'b0;
        case (r.st)
          ST_DEV: begin
            if (dev_hit) begin
              n.drv = 1'b1;
              n.hi = r.sh[2:1];
              n.st = r.sh[0] ? ST_RDAT : ST_WADR;
            end else begin
              n.st = ST_HOLD;
            end
          end
          ST_WADR: begin
            n.drv = 1'b1;
            n.addr = {r.hi, r.sh} & AMASK;
            n.st = ST_WDAT;
          end
          ST_WDAT: begin
            if (f_in_ready) begin
              push = 1'b1;
              n.drv = 1'b1;
              n.pend = 1'b1;
              n.addr = page_step(r.addr);
            end else begin
              n.st = ST_HOLD;
            end
          end
          default: begin
          end
        endcase
      end else if (r.cnt == 4'h9) begin
        n.cnt = 4'h0;
        // Zero bits pulled low, ones left to the pull-up
        n.drv = (r.st == ST_RDAT) && !rd_byte[7];
      end else if (r.st == ST_RDAT) begin
        n.drv = !rd_byte[3'(7 - r.cnt)];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.scl_st <= 1'b1;
      r.sda_st <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Never driven high, only pulled low
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = r.drv;
  assign standby = (r.st == ST_IDLE) && !r.busy;
  assign write_busy = r.busy;
  assign cur_addr = r.addr;
endmodule // tweep_target
`default_nettype wire

// [design/tweep_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tweep_ctrl
  import tweep_pkg::*;
#(
  parameter int QTR = SCL_QTR_CYC
) (
  input wire logic clock,
  input wire logic rst,
  tweep_if.ctl bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tweep_cmd_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  localparam int DW = $clog2(QTR);

  if (QTR < SCL_QTR_MIN) begin : g_chk
    $error("tweep_ctrl quarter period too short for the sampler");
  end

  typedef enum logic [1:0] {
    A_START = 2'h0,
    A_STOP = 2'h1,
    A_BIT = 2'h3
  } tweep_atom_t;

  typedef struct packed {
    logic busy;
    tweep_cmd_t op;
    logic [3:0] idx;
    logic [1:0] q;
    logic [DW-1:0] div;
    logic [7:0] sh;
    logic ack_in;
    logic scl;
    logic low;
    logic [2:0] sda_s;
    logic sda_st;
    logic [7:0] rd;
    logic rsp_v;
    logic rsp_ack;
  } tweep_ctl_s_t;

  tweep_ctl_s_t r, n;
  tweep_atom_t kind;
  logic bit_low;
  logic [3:0] last_idx;

  // Each command is a short list of start, stop and bit atoms
  always_comb begin
    kind = A_BIT;
    bit_low = 1'b0;
    last_idx = 4'h0;
    case (r.op)
      CMD_START: kind = A_START;
      CMD_STOP: kind = A_STOP;
      CMD_WRITE: begin
        last_idx = 4'(NINTH_CLK);
        if (r.idx < 4'(NINTH_CLK)) bit_low = !r.sh[3'(7 - r.idx)];
      end
      CMD_READ: begin
        last_idx = 4'(NINTH_CLK);
        bit_low = (r.idx == 4'(NINTH_CLK)) && r.ack_in;
      end
      CMD_RECOVER: begin
        // Start, nine released clocks, start, stop
        last_idx = 4'hb;
        if (r.idx == 4'h0 || r.idx == 4'ha) kind = A_START;
        else if (r.idx == 4'hb) kind = A_STOP;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    n = r;
    n.rsp_v = 1'b0;
    n.sda_s = {r.sda_s[1:0], bus.sda};
    if (r.sda_s[1] == r.sda_s[2]) n.sda_st = r.sda_s[2];
    if (!r.busy) begin
      if (cmd_valid) begin
        n.busy = 1'b1;
        n.op = cmd_op;
        n.idx = 4'h0;
        n.q = 2'h0;
        n.div = DW'(QTR - 1);
        n.sh = cmd_data;
        n.ack_in = cmd_ack;
      end
    end else if (r.div != '0) begin
      n.div = r.div - 1'b1;
    end else begin
      n.div = DW'(QTR - 1);
      n.q = r.q + 2'h1;
      // SDA moves only in quarter 0 or with SCL high for framing
      case (r.q)
        2'h0: n.low = (kind == A_STOP) || (kind == A_BIT && bit_low);
        2'h1: n.scl = 1'b1;
        2'h2: begin
          if (kind == A_START) n.low = 1'b1;
          else if (kind == A_STOP) n.low = 1'b0;
          else if (r.idx < 4'(NINTH_CLK)) n.rd = {r.rd[6:0], r.sda_st};
          else n.rsp_ack = !r.sda_st;
        end
        default: begin
          if (kind != A_STOP) n.scl = 1'b0;
          if (r.idx == last_idx) begin
            n.busy = 1'b0;
            n.rsp_v = 1'b1;
          end else begin
            n.idx = r.idx + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.scl <= 1'b1;
      r.sda_s <= 3'h7;
      r.sda_st <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign cmd_ready = !r.busy;
  assign rsp_valid = r.rsp_v;
  assign rsp_data = r.rd;
  assign rsp_ack = r.rsp_ack;
  assign bus.scl = r.scl;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_sda_oe = r.low;
endmodule // tweep_ctrl
`default_nettype wire

// [verif/tweep_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module tweep_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe
);
  logic [5:0] hi_cnt_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // High phase length; an ack never outlives one bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_cnt_r <= 6'h00;
    end else if (!scl) begin
      hi_cnt_r <= 6'h00;
    end else if (hi_cnt_r != 6'h3f) begin
      hi_cnt_r <= hi_cnt_r + 6'h01;
    end
  end
  // Target side of the wire
  property p_low_only; !tgt_sda_o; endproperty
  a_low_only: assert property (p_low_only) else $error("target drove high");
  property p_moves_low; $changed(tgt_sda_oe) |-> !scl && !$past(scl); endproperty
  a_moves_low: assert property (p_moves_low) else $error("target moved sda");
  property p_delay; $rose(tgt_sda_oe) |-> !$past(scl, 3); endproperty
  a_delay: assert property (p_delay) else $error("target drove too early");
  property p_spans; $rose(tgt_sda_oe) |-> tgt_sda_oe throughout (##[1:20] scl); endproperty
  a_spans: assert property (p_spans) else $error("target dropped before high");
  property p_hold; $rose(scl) && tgt_sda_oe |-> tgt_sda_oe [*8]; endproperty
  a_hold: assert property (p_hold) else $error("target let go in high");
  // Framing conditions keep the clock high
  property p_start; $fell(sda) && scl |-> scl [*8]; endproperty
  a_start: assert property (p_start) else $error("clock fell after start");
  property p_stop; $rose(sda) && scl |-> scl [*8]; endproperty
  a_stop: assert property (p_stop) else $error("clock fell after stop");
  property p_idle; hi_cnt_r >= 6'h28 |-> !tgt_sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("target busy on idle bus");
  c_ack: cover property ($rose(tgt_sda_oe));
  c_stop: cover property ($rose(sda) && scl);
  c_idle: cover property (hi_cnt_r == 6'h3f);
endmodule // tweep_properties
`default_nettype wire

// [verif/two_wire_eeprom_target_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t got %h exp %h", $time, (a), (b)); end end
module two_wire_eeprom_target_tb
  import tweep_pkg::*;
;
  localparam int PROG = 2000;
  logic clock, rst, cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_ack, prog_ready;
  logic standby, write_busy;
  logic [2:0] strap;
  logic [7:0] cmd_data, rsp_data, p, a, d;
  logic [9:0] cur_addr;
  logic [7:0] mem [256];
  tweep_cmd_t cmd_op;
  int err_count, checked;
  tweep_if bus ();
  tweep_ctrl u_tweep_ctrl (.clock(clock), .rst(rst), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  tweep_target #(.PROG_CYC(PROG)) u_tweep_target (.clock(clock), .rst(rst), .bus(bus),
    .strap_select_hi(strap[2]), .strap_select_mid(strap[1]), .strap_select_lo(strap[0]),
    .prog_ready(prog_ready), .standby(standby), .write_busy(write_busy),
    .cur_addr(cur_addr));
  tweep_properties u_tweep_properties (.clock(clock), .rst(rst), .scl(bus.scl),
    .sda(bus.sda), .tgt_sda_o(bus.tgt_sda_o), .tgt_sda_oe(bus.tgt_sda_oe));
  // 4 ns clock
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  // Address word for the strapped part
  function automatic logic [7:0] dev(input logic rd);
    return {DEV_TYPE_CODE, strap, rd};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One command; entered just after an edge, idle controller assumed
  task automatic cmd(input tweep_cmd_t op, input logic [7:0] dv, input logic ak);
    int n;
    n = 0;
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_data <= dv;
    cmd_ack <= ak;
    @(posedge clock);
    cmd_valid <= 1'h0;
    while (!rsp_valid && n < 2000) begin
      @(posedge clock);
      n++;
    end
    if (n == 2000) begin
      err_count++;
      report_and_stop();
    end
    `CHK(cmd_ready, 1'h1)
  endtask
  task automatic wb(input logic [7:0] dv, input logic ex);
    cmd(CMD_WRITE, dv, 1'h0);
    `CHK(rsp_ack, ex)
  endtask
  // Bounded wait for the program cycle to end
  task automatic wait_idle();
    int n;
    for (n = 0; n < 4000 && write_busy !== 1'h0; n++) @(posedge clock);
    `CHK(write_busy, 1'h0)
    if (n == 4000) report_and_stop();
  endtask
  // Random read of n bytes from w, then stop
  task automatic readback(input logic [7:0] w, input int n);
    cmd(CMD_START, 8'h00, 1'h0);
    wb(dev(1'h0), 1'h1);
    wb(w, 1'h1);
    cmd(CMD_START, 8'h00, 1'h0);
    wb(dev(1'h1), 1'h1);
    for (int i = 0; i < n; i++) begin
      cmd(CMD_READ, 8'h00, i < n - 1);
      `CHK(rsp_data, mem[w + 8'(i)])
    end
    cmd(CMD_STOP, 8'h00, 1'h0);
    `CHK(standby, 1'h1)
    `CHK(cur_addr, {2'h0, w + 8'(n)})
  endtask
  initial begin
    rst = 1'h1;
    cmd_valid = 1'h0;
    cmd_op = CMD_START;
    cmd_data = 8'h00;
    cmd_ack = 1'h0;
    prog_ready = 1'h1;
    err_count = 0;
    checked = 0;
    void'($urandom(33));
    strap = 3'($urandom());
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    repeat (8) @(posedge clock);
    `CHK(standby, 1'h1)
    `CHK(cur_addr, 10'h000)
    `CHK(bus.sda, 1'h1)
    $display("test reset done");
    // Wrong nibble or any wrong strap bit gets no ack
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_START, 8'h00, 1'h0);
      wb(dev(1'h0) ^ (8'h02 << i), 1'h0);
      cmd(CMD_STOP, 8'h00, 1'h0);
      `CHK(standby, 1'h1)
    end
    $display("test address compare done");
    // Ten bytes into an eight byte page wrap over the first two
    p = 8'($urandom());
    a = p;
    cmd(CMD_START, 8'h00, 1'h0);
    wb(dev(1'h0), 1'h1);
    wb(p, 1'h1);
    for (int i = 0; i < 10; i++) begin
      d = 8'($urandom());
      wb(d, 1'h1);
      mem[a] = d;
      a = {a[7:3], a[2:0] + 3'h1};
    end
    cmd(CMD_STOP, 8'h00, 1'h0);
    `CHK(write_busy, 1'h1)
    cmd(CMD_START, 8'h00, 1'h0);
    wb(dev(1'h0), 1'h0);
    cmd(CMD_STOP, 8'h00, 1'h0);
    wait_idle();
    p = {p[7:3], 3'h0};
    readback(p, 8);
    $display("test page write done");
    // Stalled array: four bytes fill the buffer, the fifth is refused
    prog_ready <= 1'h0;
    cmd(CMD_START, 8'h00, 1'h0);
    wb(dev(1'h0), 1'h1);
    wb(p, 1'h1);
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom());
      wb(d, i < 4);
      if (i < 4) mem[p + 8'(i)] = d;
    end
    cmd(CMD_STOP, 8'h00, 1'h0);
    repeat (PROG + 100) @(posedge clock);
    `CHK(write_busy, 1'h1)
    `CHK(standby, 1'h0)
    prog_ready <= 1'h1;
    wait_idle();
    readback(p, 8);
    $display("test buffer full done");
    // Recovery after the word address, before any data byte, leaves no program cycle behind
    cmd(CMD_START, 8'h00, 1'h0);
    wb(dev(1'h0), 1'h1);
    wb(8'($urandom()), 1'h1);
    cmd(CMD_RECOVER, 8'h00, 1'h0);
    `CHK(write_busy, 1'h0)
    `CHK(standby, 1'h1)
    readback(p + 8'h02, 4);
    $display("test recovery done");
    report_and_stop();
  end
endmodule // two_wire_eeprom_target_tb
`default_nettype wire
